// ---- rtl/system_irq_enable_flag_regs.sv ----
// system interrupt enable and flag registers with an apb slave
//
// Contract
// - enable bits 15-8 and 2 read zero and ignore writes.
// - enable bit 7 gates the mailbox output interrupt, read/write, reset 0.
// - enable bit 6 gates the mailbox input interrupt, read/write, reset 0.
// - enable bit 5 gates the flash access-violation interrupt, read/write, reset 0.
// - enable bit 4 gates the nmi pin interrupt, read/write, reset 0.
// - enable bit 3 gates the vacant-memory interrupt, read/write, reset 0.
// - enable bit 1 gates the oscillator fault interrupt, read/write, reset 0.
// - enable bit 0 gates the watchdog interval-timer interrupt, reset 0.
// - in watchdog mode the expiry action does not depend on the watchdog enable.
// - flag bit 7 flags mailbox out and resets to 1, outgoing mailbox ready.
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/10ps
module system_irq_enable_flag_regs (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [sysirq_pkg::ADDR_W-1:0] paddr,
  input  wire logic [sysirq_pkg::DATA_W-1:0] pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic      [sysirq_pkg::DATA_W-1:0] prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire sysirq_pkg::src_evt_t        src_evt,
  input  wire logic                        wdt_interval_mode,
  output sysirq_pkg::src_req_t             src_req,
  output logic                             wdt_expiry_reset,
  output logic                             irq
);
  import sysirq_pkg::*;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [REG_W-1:0] enables_reg;
  logic [REG_W-1:0] enables_next;
  logic [REG_W-1:0] flags_reg;
  logic [REG_W-1:0] flags_next;
  logic [N_SRC-1:0] evt_mask_reg;
  logic [N_SRC-1:0] evt_mask_next;
  logic [N_SRC-1:0] evt_stat_reg;
  logic [N_SRC-1:0] evt_stat_next;
  logic [DATA_W-1:0] prdata_next;
  logic [DATA_W-1:0] prdata_reg;
  logic              pslverr_next;
  logic [N_SRC-1:0]  set_pulse;
  logic              wr_acc;
  logic              rd_acc;
  logic              hit;
  logic              rd_setup;

  // sources may come from other clock domains
  sysirq_edge #(
    .W (N_SRC)
  ) u_edge (
    .pclk       (pclk),
    .presetn    (presetn),
    .async_in   (src_evt),
    .rise_pulse (set_pulse)
  );

  // byte-lane merge of a 16-bit register, honouring the writable mask
  function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old,
                                             input logic [REG_W-1:0] wd,
                                             input logic [1:0]       strb,
                                             input logic [REG_W-1:0] wmask);
    logic [REG_W-1:0] lane;
    lane = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
    return (old & ~lane) | (wd & lane);
  endfunction

  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;
  assign hit    = (paddr == ENABLES_OFFSET) || (paddr == FLAGS_OFFSET) ||
                  (paddr == IRQ_MASK_OFFSET) || (paddr == IRQ_STAT_OFFSET);
  assign pready = 1'b1;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    enables_next  = enables_reg;
    flags_next    = flags_reg;
    evt_mask_next = evt_mask_reg;
    evt_stat_next = evt_stat_reg;
    pslverr_next  = 1'b0;
    if (wr_acc && paddr == ENABLES_OFFSET) begin
      // bit set/clear style updates are done by software read-modify-write
      enables_next = merge(enables_reg, pwdata[REG_W-1:0], pstrb[1:0], ENABLES_WMASK);
    end
    if (wr_acc && paddr == FLAGS_OFFSET) begin
      flags_next = merge(flags_reg, pwdata[REG_W-1:0], pstrb[1:0], FLAGS_WMASK);
    end
    if (wr_acc && paddr == IRQ_MASK_OFFSET) begin
      evt_mask_next = pstrb[0] ? pwdata[N_SRC-1:0] & ENABLES_WMASK[N_SRC-1:0] : evt_mask_reg;
    end
    if (rd_acc && paddr == IRQ_STAT_OFFSET) begin
      evt_stat_next = '0;
    end
    // hardware set wins over a software clear in the same cycle
    flags_next    = flags_next | ({8'h00, set_pulse} & FLAGS_WMASK);
    // status keeps the enable layout, so the flash event without a flag has a bit
    evt_stat_next = evt_stat_next | (set_pulse & ENABLES_WMASK[N_SRC-1:0]);
    if (psel && penable && !hit) begin
      pslverr_next = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enables_reg  <= ENABLES_RESET;
      flags_reg    <= FLAGS_RESET;
      evt_mask_reg <= EVT_RESET;
      evt_stat_reg <= EVT_RESET;
    end else begin
      enables_reg  <= enables_next;
      flags_reg    <= flags_next;
      evt_mask_reg <= evt_mask_next;
      evt_stat_reg <= evt_stat_next;
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  // captured at the setup edge so that it stands in a flop through the
  // zero-wait access phase; next values keep an event that lands on the
  // setup edge from being missed by the read that clears the status
  assign rd_setup = psel & ~penable & ~pwrite;

  always_comb begin
    prdata_next = '0;
    if (rd_setup) begin
      unique case (paddr)
        ENABLES_OFFSET:  prdata_next = {16'h0000, enables_next & ENABLES_WMASK};
        FLAGS_OFFSET:    prdata_next = {16'h0000, flags_next & FLAGS_WMASK};
        IRQ_MASK_OFFSET: prdata_next = {24'h000000, evt_mask_next};
        IRQ_STAT_OFFSET: prdata_next = {24'h000000, evt_stat_next};
        default:         prdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  // the error flag qualifies the handshake and may stay combinational
  assign prdata  = prdata_reg;
  assign pslverr = pslverr_next;

  // ------------------------------------------------------------
  // requests to the system
  // ------------------------------------------------------------
  always_comb begin
    src_req                 = '0;
    src_req.mailbox_out     = flags_reg[BIT_MBOUT]  & enables_reg[BIT_MBOUT];
    src_req.mailbox_in      = flags_reg[BIT_MBIN]   & enables_reg[BIT_MBIN];
    // flash violation has no flag here; its sticky status bit is gated instead
    src_req.flash_violation = evt_stat_reg[BIT_FLASH] & enables_reg[BIT_FLASH];
    src_req.nmi_pin         = flags_reg[BIT_NMI]    & enables_reg[BIT_NMI];
    src_req.vacant_memory   = flags_reg[BIT_VMA]    & enables_reg[BIT_VMA];
    src_req.osc_fault       = flags_reg[BIT_OSC]    & enables_reg[BIT_OSC];
    src_req.watchdog        = flags_reg[BIT_WDT] & enables_reg[BIT_WDT]
                              & wdt_interval_mode;
  end

  // expiry in watchdog mode ignores the enable bit
  assign wdt_expiry_reset = flags_reg[BIT_WDT] & ~wdt_interval_mode;
  assign irq = |(evt_stat_reg & evt_mask_reg);

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_enable_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    (enables_reg & ~ENABLES_WMASK) == 16'h0000)
    else $error("reserved enable bits set");
  a_enable_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && paddr == ENABLES_OFFSET && pstrb[0] |=>
      enables_reg[N_SRC-1:0] == ($past(pwdata[N_SRC-1:0]) & ENABLES_WMASK[N_SRC-1:0]))
    else $error("enable write not stored");
  a_mbin_req: assert property (@(posedge pclk) disable iff (!presetn)
    src_req.mailbox_in == (flags_reg[BIT_MBIN] && enables_reg[BIT_MBIN]))
    else $error("mailbox in request wrong");
  a_flash_req: assert property (@(posedge pclk) disable iff (!presetn)
    !enables_reg[BIT_FLASH] |-> !src_req.flash_violation)
    else $error("flash request while disabled");
  a_nmi_req: assert property (@(posedge pclk) disable iff (!presetn)
    !enables_reg[BIT_NMI] |-> !src_req.nmi_pin)
    else $error("nmi request while disabled");
  a_vma_req: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(src_req.vacant_memory) |-> enables_reg[BIT_VMA])
    else $error("vacant memory request without enable");
  a_osc_req: assert property (@(posedge pclk) disable iff (!presetn)
    flags_reg[BIT_OSC] && enables_reg[BIT_OSC] |-> src_req.osc_fault)
    else $error("osc fault request missing");
  a_wdt_mode: assert property (@(posedge pclk) disable iff (!presetn)
    !wdt_interval_mode |-> !src_req.watchdog)
    else $error("watchdog request outside interval mode");
  a_wdt_expiry: assert property (@(posedge pclk) disable iff (!presetn)
    flags_reg[BIT_WDT] && !wdt_interval_mode |-> wdt_expiry_reset)
    else $error("watchdog expiry blocked");
  a_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
    set_pulse[BIT_MBOUT] |=> flags_reg[BIT_MBOUT])
    else $error("mailbox out flag lost");
  a_flag_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    (flags_reg & ~FLAGS_WMASK) == 16'h0000)
    else $error("reserved flag bits set");

  // ------------------------------------------------------------
  // reset, bus and read data checks
  // ------------------------------------------------------------
  // no disable here: it looks at the first edge after release
  a_reset_values: assert property (@(posedge pclk)
    $rose(presetn) |->
      flags_reg == FLAGS_RESET && enables_reg == ENABLES_RESET && evt_stat_reg == EVT_RESET)
    else $error("register values after reset wrong");
  a_flag_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && paddr == FLAGS_OFFSET && pstrb[0] && set_pulse == EVT_RESET |=>
      flags_reg[N_SRC-1:0] == ($past(pwdata[N_SRC-1:0]) & FLAGS_WMASK[N_SRC-1:0]))
    else $error("flag write not stored");
  a_unmapped_hold: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pwrite && !hit |=>
      $stable(enables_reg) && $stable(evt_mask_reg))
    else $error("refused write changed a register");
  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !hit |-> pslverr)
    else $error("no error on unmapped access");
  a_rdata_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !(psel && penable) |-> prdata == '0)
    else $error("read data outside access phase");
  a_enable_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
    rd_acc && paddr == ENABLES_OFFSET |->
      (prdata[REG_W-1:0] & ~ENABLES_WMASK) == 16'h0000 && prdata[DATA_W-1:REG_W] == 16'h0000)
    else $error("reserved enable bits read nonzero");
  a_flag_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
    rd_acc && paddr == FLAGS_OFFSET |->
      (prdata[REG_W-1:0] & ~FLAGS_WMASK) == 16'h0000 && prdata[DATA_W-1:REG_W] == 16'h0000)
    else $error("reserved flag bits read nonzero");

  // ------------------------------------------------------------
  // request checks
  // ------------------------------------------------------------
  a_mbout_req: assert property (@(posedge pclk) disable iff (!presetn)
    src_req.mailbox_out == (flags_reg[BIT_MBOUT] && enables_reg[BIT_MBOUT]))
    else $error("mailbox out request wrong");
  a_flash_gate: assert property (@(posedge pclk) disable iff (!presetn)
    evt_stat_reg[BIT_FLASH] && enables_reg[BIT_FLASH] |-> src_req.flash_violation)
    else $error("flash request missing");
  a_nmi_gate: assert property (@(posedge pclk) disable iff (!presetn)
    flags_reg[BIT_NMI] && enables_reg[BIT_NMI] |-> src_req.nmi_pin)
    else $error("nmi request missing");
  a_vma_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !enables_reg[BIT_VMA] |-> !src_req.vacant_memory)
    else $error("vacant memory request while disabled");
  a_osc_off: assert property (@(posedge pclk) disable iff (!presetn)
    !enables_reg[BIT_OSC] |-> !src_req.osc_fault)
    else $error("osc fault request while disabled");
  a_wdt_gate: assert property (@(posedge pclk) disable iff (!presetn)
    flags_reg[BIT_WDT] && enables_reg[BIT_WDT] && wdt_interval_mode |-> src_req.watchdog)
    else $error("watchdog request missing");
  a_wdt_disabled: assert property (@(posedge pclk) disable iff (!presetn)
    !enables_reg[BIT_WDT] |-> !src_req.watchdog)
    else $error("watchdog request while disabled");
  a_expiry_interval: assert property (@(posedge pclk) disable iff (!presetn)
    wdt_interval_mode |-> !wdt_expiry_reset)
    else $error("watchdog expiry in interval mode");

  // ------------------------------------------------------------
  // event status checks
  // ------------------------------------------------------------
  // a set in the clearing cycle survives, so it is left out of the clear check
  a_flash_status: assert property (@(posedge pclk) disable iff (!presetn)
    set_pulse[BIT_FLASH] |=> evt_stat_reg[BIT_FLASH])
    else $error("flash event not latched");
  a_status_clear: assert property (@(posedge pclk) disable iff (!presetn)
    rd_acc && paddr == IRQ_STAT_OFFSET |=>
      (evt_stat_reg & ~$past(set_pulse & ENABLES_WMASK[N_SRC-1:0])) == EVT_RESET)
    else $error("status not cleared by read");
  a_status_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    evt_stat_reg != EVT_RESET && !(rd_acc && paddr == IRQ_STAT_OFFSET) |=>
      (evt_stat_reg & $past(evt_stat_reg)) == $past(evt_stat_reg))
    else $error("status bit lost without read");
  a_irq_masked: assert property (@(posedge pclk) disable iff (!presetn)
    evt_mask_reg == EVT_RESET |-> !irq)
    else $error("interrupt while all masked");

  // ------------------------------------------------------------
  // coverage
  // ------------------------------------------------------------
  c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
  c_wdt_reset: cover property (@(posedge pclk) disable iff (!presetn) $rose(wdt_expiry_reset));
  c_flag_clear: cover property (@(posedge pclk) disable iff (!presetn)
    $fell(flags_reg[BIT_MBOUT]));
  c_flash_req: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(src_req.flash_violation));
  c_status_read: cover property (@(posedge pclk) disable iff (!presetn)
    rd_acc && paddr == IRQ_STAT_OFFSET && evt_stat_reg != EVT_RESET);
endmodule

// ---- rtl/sysirq_pkg.sv ----
// constants and types shared by the system interrupt enable and flag registers
package sysirq_pkg;
  localparam int          DATA_W           = 32;
  localparam int          REG_W            = 16;
  localparam int          ADDR_W           = 12;
  localparam logic [11:0] ENABLES_OFFSET   = 12'h000;
  localparam logic [11:0] FLAGS_OFFSET     = 12'h004;
  localparam logic [11:0] IRQ_MASK_OFFSET  = 12'h008;
  localparam logic [11:0] IRQ_STAT_OFFSET  = 12'h00C;
  localparam logic [15:0] ENABLES_RESET    = 16'h0000;
  localparam logic [15:0] ENABLES_WMASK    = 16'h00FB;
  localparam logic [15:0] FLAGS_RESET      = 16'h0082;
  localparam logic [15:0] FLAGS_WMASK      = 16'h00DB;
  localparam logic [7:0]  EVT_RESET        = 8'h00;
  localparam int          BIT_WDT          = 0;
  localparam int          BIT_OSC          = 1;
  localparam int          BIT_VMA          = 3;
  localparam int          BIT_NMI          = 4;
  localparam int          BIT_FLASH        = 5;
  localparam int          BIT_MBIN         = 6;
  localparam int          BIT_MBOUT        = 7;
  localparam int          N_SRC            = 8;

  // source event levels from the system, synchronised into set pulses on a rising change, by flag bit position
  typedef struct packed {
    logic mailbox_out;
    logic mailbox_in;
    logic flash_violation;
    logic nmi_pin;
    logic vacant_memory;
    logic reserved2;
    logic osc_fault;
    logic watchdog;
  } src_evt_t;

  // per-source interrupt requests to the system
  typedef struct packed {
    logic mailbox_out;
    logic mailbox_in;
    logic flash_violation;
    logic nmi_pin;
    logic vacant_memory;
    logic reserved2;
    logic osc_fault;
    logic watchdog;
  } src_req_t;
endpackage

// ---- rtl/sysirq_edge.sv ----
// source event synchroniser: three flops, a rising change counts when stages two and three agree
`timescale 1ns/10ps
module sysirq_edge #(
  parameter int W = 8
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] rise_pulse
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] lvl_reg;
  logic [W-1:0] lvl_next;
  logic [W-1:0] rise_next;

  always_comb begin
    lvl_next  = lvl_reg;
    rise_next = '0;
    for (int i = 0; i < W; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        lvl_next[i]  = s3_reg[i];
        rise_next[i] = s3_reg[i] & ~lvl_reg[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg     <= '0;
      s2_reg     <= '0;
      s3_reg     <= '0;
      lvl_reg    <= '0;
      rise_pulse <= '0;
    end else begin
      s1_reg     <= async_in;
      s2_reg     <= s1_reg;
      s3_reg     <= s2_reg;
      lvl_reg    <= lvl_next;
      rise_pulse <= rise_next;
    end
  end
endmodule

// ---- verification/system_irq_enable_flag_regs_tb_top.sv ----
// self-checking bench for the system interrupt enable and flag registers
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin errors++; \
  $display("BAD %s exp %h got %h", nm, ex, got); end end
module system_irq_enable_flag_regs_tb_top;
  import sysirq_pkg::*;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [3:0]        pstrb = 4'h0;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  src_evt_t          src_evt = '0;
  logic              wdt_interval_mode = 1'b0;
  src_req_t          src_req;
  logic              wdt_expiry_reset;
  logic              irq;
  int                errors = 0;
  int                num_checks = 0;
  int                cyc = 0;
  int                seed = 32'h2194;
  logic [31:0]       v;
  logic [31:0]       rd;
  logic              er;

  system_irq_enable_flag_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_evt(src_evt),
    .wdt_interval_mode(wdt_interval_mode), .src_req(src_req),
    .wdt_expiry_reset(wdt_expiry_reset), .irq(irq));

  always #25 pclk = ~pclk;

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 4000) begin
      errors++;
      stop_test();
    end
  end

  // ----------------------------------------
  // bus helpers
  // ----------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, s, r, e);
  endtask

  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] ex);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, 4'h0, r, e);
    `CHK(nm, ex, r)
  endtask

  function automatic logic [31:0] en_exp(input logic [31:0] w);
    return {16'h0000, w[15:0] & ENABLES_WMASK};
  endfunction

  function automatic logic [31:0] fl_exp(input logic [31:0] w);
    return {16'h0000, w[15:0] & FLAGS_WMASK};
  endfunction

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rchk("enables reset", ENABLES_OFFSET, 32'h0000_0000);
    rchk("flags reset", FLAGS_OFFSET, 32'h0000_0082);
    $display("test reset done");
    // walking ones first, then the all-ones word and random words
    for (int i = 0; i < 24; i++) begin
      v = (i < 16) ? (32'h1 << i) : $random(seed);
      if (i == 16) v = 32'hFFFF_FFFF;
      wr(ENABLES_OFFSET, v, 4'hF);
      rchk("enables rw", ENABLES_OFFSET, en_exp(v));
      wr(FLAGS_OFFSET, v, 4'hF);
      rchk("flags rw", FLAGS_OFFSET, fl_exp(v));
    end
    // high lane only: low byte must stay put
    wr(FLAGS_OFFSET, 32'h0000_00C0, 4'hF);
    wr(FLAGS_OFFSET, 32'hFFFF_FFFF, 4'h2);
    rchk("flags lane", FLAGS_OFFSET, 32'h0000_00C0);
    apb(1'b0, 12'h010, 32'h0, 4'h0, rd, er);
    `CHK("unmapped err", 1'b1, er)
    `CHK("unmapped data", 32'h0, rd)
    apb(1'b1, 12'h010, 32'hFFFF_FFFF, 4'hF, rd, er);
    `CHK("unmapped wr err", 1'b1, er)
    rchk("enables after refused", ENABLES_OFFSET, en_exp(v));
    $display("test registers done");
    wr(ENABLES_OFFSET, 32'h0000_00FF, 4'hF);
    wr(FLAGS_OFFSET, 32'h0000_00DB, 4'hF);
    wdt_interval_mode <= 1'b1;
    @(negedge pclk);
    `CHK("req interval", 8'hDB, src_req)
    `CHK("expiry interval", 1'b0, wdt_expiry_reset)
    wdt_interval_mode <= 1'b0;
    @(negedge pclk);
    `CHK("req wd mode", 8'hDA, src_req)
    `CHK("expiry wd mode", 1'b1, wdt_expiry_reset)
    wr(ENABLES_OFFSET, 32'h0, 4'hF);
    @(negedge pclk);
    `CHK("req disabled", 8'h00, src_req)
    `CHK("expiry no enable", 1'b1, wdt_expiry_reset)
    $display("test requests done");
    wr(FLAGS_OFFSET, 32'h0, 4'hF);
    @(posedge pclk);
    src_evt.nmi_pin <= 1'b1;
    repeat (8) @(posedge pclk);
    rchk("nmi flag set", FLAGS_OFFSET, 32'h0000_0010);
    @(negedge pclk);
    `CHK("irq masked", 1'b0, irq)
    wr(IRQ_MASK_OFFSET, 32'h0000_0010, 4'hF);
    @(negedge pclk);
    `CHK("irq unmasked", 1'b1, irq)
    rchk("status", IRQ_STAT_OFFSET, 32'h0000_0010);
    @(negedge pclk);
    `CHK("irq cleared", 1'b0, irq)
    src_evt <= '0;
    // two-bit set, then single-bit clear, by read-modify-write of the shared low byte
    apb(1'b0, ENABLES_OFFSET, 32'h0, 4'h0, rd, er);
    wr(ENABLES_OFFSET, rd | 32'h0000_0021, 4'h1);
    rchk("enables bit set", ENABLES_OFFSET, 32'h0000_0021);
    src_evt.flash_violation <= 1'b1;
    repeat (8) @(posedge pclk);
    @(negedge pclk);
    `CHK("flash req", 1'b1, src_req.flash_violation)
    `CHK("irq flash masked", 1'b0, irq)
    rchk("flash status", IRQ_STAT_OFFSET, 32'h0000_0020);
    @(negedge pclk);
    `CHK("flash req cleared", 1'b0, src_req.flash_violation)
    apb(1'b0, ENABLES_OFFSET, 32'h0, 4'h0, rd, er);
    wr(ENABLES_OFFSET, rd & ~32'h0000_0001, 4'h1);
    rchk("enables bit clear", ENABLES_OFFSET, 32'h0000_0020);
    src_evt <= '0;
    $display("test events done");
    stop_test();
  end
endmodule
